//--- rtl/rx_status_pkg.sv
// shared constants and types for the receiver status flag bank
package rx_status_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_ERR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_SLIP_STATUS = 8'h15;
    localparam logic [7:0] ADDR_MASK_1 = 8'h16;
    localparam logic [7:0] ADDR_MASK_2 = 8'h17;
    localparam logic [7:0] MASK_1_RESET = 8'h00;
    localparam logic MASK_2_RESET = 1'b0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // field positions in the status and mask registers
    localparam int BIT_CHAN_STAT_CRC = 7;
    localparam int BIT_PARITY = 6;
    localparam int BIT_VALIDITY = 5;
    localparam int BIT_BIPHASE = 4;
    localparam int BIT_SUBCODE_CHG = 3;
    localparam int BIT_LOCK_LOSS = 2;
    localparam int BIT_SUBCODE_CRC = 1;
    localparam int BIT_BUFFER_XFER = 0;
    localparam int BIT_OUTPUT_SLIP = 0;
    // frame clock slip window, percent of a receiver frame
    localparam int SLIP_WINDOW_PCT = 5;
    localparam int PCT_FULL = 100;
    localparam int FRAME_CNT_W = 16;

    // receiver decoder report, packed in status-register bit order
    typedef struct packed {
        logic chan_stat_crc_err;
        logic parity_err;
        logic validity_flag;
        logic biphase_err;
        logic subcode_changed;
        logic lock_loss;
        logic subcode_crc_err;
        logic buffer_xfer_done;
    } rx_report_t;

    // routing of the receiver output to the two serial ports
    typedef struct packed {
        logic port_a_from_rx;
        logic port_a_slave;
        logic port_b_from_rx;
        logic port_b_slave;
    } port_route_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic wr;
        logic rd;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;
endpackage

//--- rtl/slip_detect.sv
// output slip detector for the slave serial port frame clocks
`timescale 1ns/1ps
module slip_detect #(
    parameter int CNT_W = rx_status_pkg::FRAME_CNT_W
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire rx_status_pkg::port_route_t route_i,
    input wire logic rx_frame_tick_i,
    input wire logic frame_clock_a_i,
    input wire logic frame_clock_b_i,
    output logic slip_o
);
    import rx_status_pkg::*;

    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic [1:0] prev_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] win;
    logic a_armed;
    logic b_armed;
    logic use_a;
    logic edge_sel;
    logic near_edge;

    // two-stage synchronisers for the port frame clocks
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q <= 2'h0;
        end else begin
            sync1_q <= {frame_clock_b_i, frame_clock_a_i};
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // measure receiver output frame period
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            cnt_q <= '0;
            period_q <= '0;
        end else if (rx_frame_tick_i) begin
            cnt_q <= '0;
            period_q <= cnt_q;
        end else if (cnt_q != '1) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign win = CNT_W'((32'(period_q) * SLIP_WINDOW_PCT) / PCT_FULL);
    assign a_armed = route_i.port_a_from_rx && route_i.port_a_slave;
    assign b_armed = route_i.port_b_from_rx && route_i.port_b_slave;
    // port a wins whenever it is fed by the receiver
    assign use_a = route_i.port_a_from_rx;
    assign edge_sel = use_a ? (sync2_q[0] != prev_q[0])
                            : (sync2_q[1] != prev_q[1]);
    // one extra bit so a saturated count cannot wrap past the period
    assign near_edge = (cnt_q <= win)
                       || (({1'b0, cnt_q} + {1'b0, win})
                           >= {1'b0, period_q});

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            slip_o <= 1'b0;
        end else begin
            slip_o <= edge_sel && near_edge && (period_q != '0)
                      && (use_a ? a_armed : b_armed);
        end
    end
endmodule // slip_detect

//--- rtl/receiver_status_flags.sv
// receiver status flag bank with masks and interrupt gating
`timescale 1ns/1ps
//
// Contract
// - error flags interrupt only when 0x16 unmasked
// - slip flag interrupts only when 0x17 unmasked
// - crc, parity, biphase flags read 1 on error
// - validity bit follows audio valid marking
// - sub-code change flag set on new data
// - lock-loss flag high while unlocked
// - sub-code crc flag set on crc error
// - buffer flag set after buffer copy
// - slip flag bit 0, upper bits zero
// - slip only for receiver-fed slave port
// - both ports fed: slip tracks port a
// - slip when frame edges within 5 percent
// - masks reset to zero, one enables
module receiver_status_flags #(
    parameter int CNT_W = rx_status_pkg::FRAME_CNT_W
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire rx_status_pkg::reg_req_t reg_req_i,
    input wire rx_status_pkg::rx_report_t report_i,
    input wire rx_status_pkg::port_route_t route_i,
    input wire logic rx_frame_tick_i,
    input wire logic frame_clock_a_i,
    input wire logic frame_clock_b_i,
    output logic [rx_status_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    output logic irq_o
);
    import rx_status_pkg::*;

    logic [DATA_W-1:0] err_q;
    logic slip_q;
    logic [DATA_W-1:0] mask1_q;
    logic mask2_q;
    logic [DATA_W-1:0] err_view;
    logic [DATA_W-1:0] slip_view;
    logic [DATA_W-1:0] rd_mux;
    logic [DATA_W-1:0] sticky_set;
    logic [DATA_W-1:0] sticky_sel;
    logic clr_err;
    logic clr_slip;
    logic slip_pulse;

    slip_detect #(.CNT_W(CNT_W)) u_slip (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .route_i(route_i),
        .rx_frame_tick_i(rx_frame_tick_i),
        .frame_clock_a_i(frame_clock_a_i),
        .frame_clock_b_i(frame_clock_b_i),
        .slip_o(slip_pulse)
    );

    // event bits latch until read; validity and lock follow live levels
    assign sticky_sel = ~((DATA_W'(1) << BIT_VALIDITY)
                        | (DATA_W'(1) << BIT_LOCK_LOSS));
    assign sticky_set = report_i & sticky_sel;
    assign clr_err = reg_req_i.rd && (reg_req_i.addr == ADDR_ERR_STATUS);
    assign clr_slip = reg_req_i.rd && (reg_req_i.addr == ADDR_SLIP_STATUS);

    // sticky error flags, set wins over clear-on-read
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            err_q <= STATUS_RESET;
        end else if (clr_err) begin
            err_q <= sticky_set;
        end else begin
            err_q <= err_q | sticky_set;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            slip_q <= 1'b0;
        end else begin
            slip_q <= slip_pulse | (slip_q & ~clr_slip);
        end
    end

    always_comb begin
        err_view = err_q & sticky_sel;
        err_view[BIT_VALIDITY] = report_i.validity_flag;
        err_view[BIT_LOCK_LOSS] = report_i.lock_loss;
    end

    assign slip_view = {{(DATA_W-1){1'b0}}, slip_q};

    // mask registers; status addresses take no writes
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mask1_q <= MASK_1_RESET;
            mask2_q <= MASK_2_RESET;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == ADDR_MASK_1) begin
                mask1_q <= reg_req_i.wdata;
            end
            if (reg_req_i.addr == ADDR_MASK_2) begin
                mask2_q <= reg_req_i.wdata[BIT_OUTPUT_SLIP];
            end
        end
    end

    always_comb begin
        unique case (reg_req_i.addr)
            ADDR_ERR_STATUS: rd_mux = err_view;
            ADDR_SLIP_STATUS: rd_mux = slip_view;
            ADDR_MASK_1: rd_mux = mask1_q;
            ADDR_MASK_2: rd_mux = {{(DATA_W-1){1'b0}}, mask2_q};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                reg_rdata_o <= rd_mux;
            end
        end
    end

    // level interrupt from unmasked flags
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (|(err_view & mask1_q))
                     | (slip_q & mask2_q);
        end
    end
endmodule // receiver_status_flags

//--- verif/rsf_properties.sv
// port assertions for the receiver status flag bank
`timescale 1ns/1ps
module rsf_properties
    import rx_status_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire rx_status_pkg::reg_req_t reg_req_i,
    input wire rx_status_pkg::rx_report_t report_i,
    input wire logic [rx_status_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic irq_o
);
    logic [7:0] m1_q;
    logic m2_q;
    logic [7:0] ev_q;
    wire logic rd_e = reg_req_i.rd && reg_req_i.addr == ADDR_ERR_STATUS;
    wire logic rd_o = reg_req_i.rd && !reg_req_i.wr;
    // mirror of the mask registers
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            m1_q <= MASK_1_RESET;
            m2_q <= MASK_2_RESET;
        end else if (reg_req_i.wr && reg_req_i.addr == ADDR_MASK_1) begin
            m1_q <= reg_req_i.wdata;
        end else if (reg_req_i.wr && reg_req_i.addr == ADDR_MASK_2) begin
            m2_q <= reg_req_i.wdata[0];
        end
    end
    always_ff @(posedge clk_sys_i) begin
        ev_q <= report_i & 8'hDB;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    mask_gate_a: assert property (
        irq_o |-> $past(m1_q) != 8'h00 || $past(m2_q)) else $error("irq masked");
    mask_read_a: assert property (
        rd_o && reg_req_i.addr == ADDR_MASK_1 |=> reg_rdata_o == $past(m1_q))
        else $error("mask1 read");
    mask2_read_a: assert property (
        rd_o && reg_req_i.addr == ADDR_MASK_2 |=>
        reg_rdata_o == {7'h00, $past(m2_q)}) else $error("mask2 read");
    slip_upper_a: assert property (
        reg_req_i.rd && reg_req_i.addr == ADDR_SLIP_STATUS |=>
        reg_rdata_o[7:1] == 7'h00) else $error("slip upper bits");
    validity_live_a: assert property (
        rd_e && $stable(report_i.validity_flag) |=>
        reg_rdata_o[5] == $past(report_i.validity_flag)) else $error("validity");
    lock_live_a: assert property (
        rd_e && $stable(report_i.lock_loss) |=>
        reg_rdata_o[2] == $past(report_i.lock_loss)) else $error("lock loss");
    event_sticky_a: assert property (
        rd_e |=> (reg_rdata_o & $past(ev_q)) == $past(ev_q))
        else $error("event lost");
    lock_irq_a: assert property (
        (m1_q[2] && report_i.lock_loss) [*3] |-> irq_o) else $error("lock irq");
    cover property (irq_o);
    cover property (rd_e ##1 reg_rdata_o == 8'hDB);
    cover property (reg_rdata_o == 8'h01);
endmodule // rsf_properties

//--- verif/tb.sv
// self-checking bench for the receiver status flag bank
`timescale 1ns/1ps
module tb;
    import rx_status_pkg::*;
    logic clk_sys_i = 0;
    logic reset_i = 1;
    logic tick = 0;
    logic fc = 0;
    reg_req_t req = '0;
    rx_report_t rep = '0;
    port_route_t route = '0;
    logic [7:0] rdata;
    logic rvalid;
    logic irq;
    int err_count = 0;
    int tests_run = 0;
    int cnt = 0;
    int ph = 16;
    always #50 clk_sys_i = ~clk_sys_i;
    receiver_status_flags dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .reg_req_i(req), .report_i(rep), .route_i(route),
        .rx_frame_tick_i(tick), .frame_clock_a_i(fc), .frame_clock_b_i(fc),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .irq_o(irq));
    // receiver frame of 40 cycles; port frame clocks toggle at phase ph
    always @(posedge clk_sys_i) begin
        cnt <= cnt == 39 ? 0 : cnt + 1;
        tick <= cnt == 39;
        if (cnt == ph) fc <= ~fc;
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk_sys_i);
        req <= '0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk_sys_i);
        req <= '0;
        #1 chk("read", e, rdata);
        chk("rvalid", 8'h01, {7'h00, rvalid});
        @(posedge clk_sys_i);
    endtask
    task automatic pulse(rx_report_t v, logic e);
        rep <= v;
        repeat (3) @(posedge clk_sys_i);
        #1 chk("irq", {7'h00, e}, {7'h00, irq});
        @(posedge clk_sys_i);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        for (int a = 'h14; a < 'h18; a++) rd(a[7:0], 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_MASK_1, 8'h01 << i);
            pulse(~(8'h01 << i), 1'b0);
            pulse(8'h01 << i, 1'b1);
            rep <= '0;
            repeat (2) @(posedge clk_sys_i);
            rd(ADDR_ERR_STATUS, 8'hDB);
        end
        rep <= 8'h01;
        @(posedge clk_sys_i);
        rep <= 8'h24;
        rd(ADDR_ERR_STATUS, 8'h25);
        rd(ADDR_ERR_STATUS, 8'h24);
        rep <= '0;
        wr(ADDR_ERR_STATUS, 8'hFF);
        wr(ADDR_SLIP_STATUS, 8'hFF);
        rd(ADDR_ERR_STATUS, 8'h00);
        rd(ADDR_SLIP_STATUS, 8'h00);
        wr(ADDR_MASK_1, 8'hA5);
        rd(ADDR_MASK_1, 8'hA5);
        wr(ADDR_MASK_1, 8'h00);
        wr(ADDR_MASK_2, 8'hFF);
        rd(ADDR_MASK_2, 8'h01);
        rd(8'h30, 8'h00);
        route <= 4'b1100;
        repeat (200) @(posedge clk_sys_i);
        rd(ADDR_SLIP_STATUS, 8'h00);
        route <= 4'b1011;
        ph <= 36;
        repeat (200) @(posedge clk_sys_i);
        rd(ADDR_SLIP_STATUS, 8'h00);
        route <= 4'b0011;
        repeat (200) @(posedge clk_sys_i);
        #1 chk("slip irq", 8'h01, {7'h00, irq});
        @(posedge clk_sys_i);
        rd(ADDR_SLIP_STATUS, 8'h01);
        final_report();
    end
endmodule // tb
bind receiver_status_flags rsf_properties chk_u (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .reg_req_i(reg_req_i), .report_i(report_i),
    .reg_rdata_o(reg_rdata_o), .irq_o(irq_o));
